// *** design/lcsr_pkg.sv ***
package lcsr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] LCSR_CH2_HIGH_OFS = 8'h05;
    localparam logic [7:0] LCSR_CH2_LOW_OFS = 8'h06;
    localparam logic [7:0] LCSR_CH3_HIGH_OFS = 8'h07;
    localparam logic [7:0] LCSR_CH3_LOW_OFS = 8'h08;
    localparam logic [7:0] LCSR_SWITCH_OFS = 8'h09;
    localparam logic [7:0] LCSR_DIRECT_OFS = 8'h11;
    localparam logic [7:0] LCSR_RESET_VAL = 8'h00;
    localparam logic [7:0] LCSR_UNMAPPED_VAL = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LCSR_CH3_SW_BIT = 7;
    localparam int LCSR_CH2_SW_BIT = 6;
    localparam int LCSR_CH1_SW_BIT = 5;
    localparam int LCSR_TRIM_MSB = 4;
    localparam int LCSR_DIRECT_EN_BIT = 0;
    localparam int LCSR_CODE_W = 10;
    localparam int LCSR_TRIM_W = 5;
    // ------------------------------------------------------------
    // Analog scale, in microamps and millivolts
    // ------------------------------------------------------------
    localparam logic [11:0] LCSR_STEP_UA = 12'h9A6;
    localparam logic [11:0] LCSR_UVLO_MIN_MV = 12'h942;
    localparam logic [11:0] LCSR_UVLO_STEP_MV = 12'h046;
endpackage : lcsr_pkg

// *** design/lcsr_scale.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Linear code to analog-target scaler
// ------------------------------------------------------------
module lcsr_scale
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] code,
    input wire logic [11:0] step,
    input wire logic [11:0] base,
    output logic [21:0] value
);
    import lcsr_pkg::*;
    // Registered product keeps the top outputs flop-driven
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            value <= 22'h000000;
        else
            value <= 22'({12'h000, code} * {10'h000, step}) + 22'(base);
    end
endmodule : lcsr_scale
`default_nettype wire

// *** design/lcsr_regs.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// LED channel current and switch control register slice
// ------------------------------------------------------------
module lcsr_regs
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic [9:0] ch3_current_code,
    output logic [9:0] ch2_current_code,
    output logic ch3_switch,
    output logic ch2_switch,
    output logic ch1_switch,
    output logic direct_mode,
    output logic [4:0] lockout_threshold_trim,
    output logic [21:0] ch3_current_ua,
    output logic [21:0] ch2_current_ua,
    output logic [21:0] lockout_threshold_mv
);
    import lcsr_pkg::*;

    // Bit positions in the decoded offset select
    localparam int SEL_CH3_HIGH = 0;
    localparam int SEL_CH3_LOW = 1;
    localparam int SEL_CH2_HIGH = 2;
    localparam int SEL_CH2_LOW = 3;
    localparam int SEL_SWITCH = 4;
    localparam int SEL_DIRECT = 5;

    logic [7:0] ch3_current_high;
    logic [7:0] ch3_current_low;
    logic [7:0] ch2_high;
    logic [7:0] ch2_low;
    logic [7:0] switch_direct_and_lockout_trim;
    logic [7:0] direct_ctrl;
    logic [7:0] next_rdata;
    logic [5:0] wr_sel;
    logic [5:0] rd_sel;
    logic [2:0] switch_req;
    logic [2:0] switch_out;

    // ------------------------------------------------------------
    // Offset decode
    // ------------------------------------------------------------
    // One decoder for both paths, so writes and reads never disagree
    function automatic logic [5:0] decode_offset(input logic [7:0] offset);
        logic [5:0] sel;
        sel = 6'h00;
        case (offset)
            LCSR_CH3_HIGH_OFS: sel[SEL_CH3_HIGH] = 1'b1;
            LCSR_CH3_LOW_OFS: sel[SEL_CH3_LOW] = 1'b1;
            LCSR_CH2_HIGH_OFS: sel[SEL_CH2_HIGH] = 1'b1;
            LCSR_CH2_LOW_OFS: sel[SEL_CH2_LOW] = 1'b1;
            LCSR_SWITCH_OFS: sel[SEL_SWITCH] = 1'b1;
            LCSR_DIRECT_OFS: sel[SEL_DIRECT] = 1'b1;
            default: sel = 6'h00; // Unmapped offsets select nothing
        endcase
        return sel;
    endfunction : decode_offset

    // Write select gated by the strobe; read select gated at the data flop
    assign wr_sel = {6{wr}} & decode_offset(addr);
    assign rd_sel = decode_offset(addr);

    // ------------------------------------------------------------
    // Register writes, one process per byte
    // ------------------------------------------------------------
    // Full byte stored, so undefined bits read back what was written
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ch3_current_high <= LCSR_RESET_VAL;
        else if (wr_sel[SEL_CH3_HIGH])
            ch3_current_high <= wdata;
    end

    // Channel 3 low byte
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ch3_current_low <= LCSR_RESET_VAL;
        else if (wr_sel[SEL_CH3_LOW])
            ch3_current_low <= wdata;
    end

    // Channel 2 high byte, upper bits kept like channel 3
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ch2_high <= LCSR_RESET_VAL;
        else if (wr_sel[SEL_CH2_HIGH])
            ch2_high <= wdata;
    end

    // Channel 2 low byte
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ch2_low <= LCSR_RESET_VAL;
        else if (wr_sel[SEL_CH2_LOW])
            ch2_low <= wdata;
    end

    // Switch and trim byte, stored whatever the mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            switch_direct_and_lockout_trim <= LCSR_RESET_VAL;
        else if (wr_sel[SEL_SWITCH])
            switch_direct_and_lockout_trim <= wdata;
    end

    // Direct mode byte, spare bits stored for read back
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            direct_ctrl <= LCSR_RESET_VAL;
        else if (wr_sel[SEL_DIRECT])
            direct_ctrl <= wdata;
    end

    // ------------------------------------------------------------
    // Read mux, data one cycle after the strobe
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = ({8{rd_sel[SEL_CH3_HIGH]}} & ch3_current_high)
            | ({8{rd_sel[SEL_CH3_LOW]}} & ch3_current_low)
            | ({8{rd_sel[SEL_CH2_HIGH]}} & ch2_high)
            | ({8{rd_sel[SEL_CH2_LOW]}} & ch2_low)
            | ({8{rd_sel[SEL_SWITCH]}} & switch_direct_and_lockout_trim)
            | ({8{rd_sel[SEL_DIRECT]}} & direct_ctrl)
            | ({8{rd_sel == 6'h00}} & LCSR_UNMAPPED_VAL);
    end

    // Read data held only for the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (rd)
            rdata <= next_rdata;
        else
            rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    // Full 10-bit range passed through, no clamp
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch3_current_code <= 10'h000;
            ch2_current_code <= 10'h000;
            lockout_threshold_trim <= 5'h00;
            direct_mode <= 1'b0;
        end
        else
        begin
            ch3_current_code <= {ch3_current_high[1:0], ch3_current_low};
            ch2_current_code <= {ch2_high[1:0], ch2_low};
            lockout_threshold_trim <= switch_direct_and_lockout_trim[LCSR_TRIM_MSB:0];
            direct_mode <= direct_ctrl[LCSR_DIRECT_EN_BIT];
        end
    end

    // Stored switch requests, index 0 for channel 1 up to 2 for channel 3
    assign switch_req = {switch_direct_and_lockout_trim[LCSR_CH3_SW_BIT],
        switch_direct_and_lockout_trim[LCSR_CH2_SW_BIT],
        switch_direct_and_lockout_trim[LCSR_CH1_SW_BIT]};

    // Switch bits gated by direct mode; stored value kept either way
    for (genvar i = 0; i < 3; i++)
    begin : g_switch
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                switch_out[i] <= 1'b0;
            else
                switch_out[i] <= direct_ctrl[LCSR_DIRECT_EN_BIT]
                    & switch_req[i];
        end
    end

    // Ports taken straight from the gated flops
    assign ch1_switch = switch_out[0];
    assign ch2_switch = switch_out[1];
    assign ch3_switch = switch_out[2];

    // ------------------------------------------------------------
    // Analog targets, one clock behind the codes
    // ------------------------------------------------------------
    lcsr_scale u_ch3_scale
    (
        .clk(clk),
        .rst_n(rst_n),
        .code(ch3_current_code),
        .step(LCSR_STEP_UA),
        .base(12'h000),
        .value(ch3_current_ua)
    );

    lcsr_scale u_ch2_scale
    (
        .clk(clk),
        .rst_n(rst_n),
        .code(ch2_current_code),
        .step(LCSR_STEP_UA),
        .base(12'h000),
        .value(ch2_current_ua)
    );

    lcsr_scale u_uvlo_scale
    (
        .clk(clk),
        .rst_n(rst_n),
        .code({5'h00, lockout_threshold_trim}),
        .step(LCSR_UVLO_STEP_MV),
        .base(LCSR_UVLO_MIN_MV),
        .value(lockout_threshold_mv)
    );
endmodule : lcsr_regs
`default_nettype wire

// *** verification/lcsr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module lcsr_checker
    import lcsr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [9:0] ch3_current_code,
    input wire logic ch3_switch,
    input wire logic direct_mode,
    input wire logic [4:0] lockout_threshold_trim,
    input wire logic [21:0] ch3_current_ua,
    input wire logic [21:0] lockout_threshold_mv
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Read data is quiet outside the answer cycle
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    AST_LOW3: assert property (wr && addr == 8'h08 |-> ##2 ch3_current_code[7:0] == $past(wdata, 2))
        else $error("low setpoint byte not applied");
    AST_HIGH3: assert property (wr && addr == 8'h07 |->
        ##2 {6'h00, ch3_current_code[9:8]} == ($past(wdata, 2) & 8'h03))
        else $error("high setpoint bits not applied");
    AST_SW3: assert property (wr && addr == 8'h09 |->
        ##2 (!direct_mode || ch3_switch == ($past(wdata, 2) > 8'h7F)))
        else $error("switch bit not applied");
    AST_GATE: assert property (ch3_switch |-> direct_mode)
        else $error("switch on outside direct mode");
    AST_TRIM: assert property (wr && addr == 8'h09 |->
        ##2 {3'h0, lockout_threshold_trim} == ($past(wdata, 2) & 8'h1F))
        else $error("trim not applied");
    // Scaled targets trail their code by one flop
    AST_UA: assert property (ch3_current_ua == {10'h000, LCSR_STEP_UA} * {12'h000, $past(ch3_current_code)})
        else $error("current scale wrong");
    AST_MV: assert property ($past(rst_n) |-> lockout_threshold_mv ==
        {10'h000, LCSR_UVLO_MIN_MV} + {10'h000, LCSR_UVLO_STEP_MV} * {17'h0, $past(lockout_threshold_trim)})
        else $error("threshold scale wrong");
endmodule : lcsr_checker
bind lcsr_regs lcsr_checker u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ch3_current_code(ch3_current_code),
    .ch3_switch(ch3_switch), .direct_mode(direct_mode),
    .lockout_threshold_trim(lockout_threshold_trim), .ch3_current_ua(ch3_current_ua),
    .lockout_threshold_mv(lockout_threshold_mv));
`default_nettype wire

// *** verification/lcsr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Host controller model
// ----
module lcsr_host
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd
);
    initial
    begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Lines are scrambled after use so stale values never pass for good ones
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : read_reg
endmodule : lcsr_host
`default_nettype wire

// *** verification/led_current_switch_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module led_current_switch_regs_bench;
    import lcsr_pkg::*;
    logic clk, rst_n, wr, rd, sw3, sw2, sw1, dmode;
    logic [7:0] addr, wdata, rdata, rv;
    logic [9:0] code3, code2;
    logic [4:0] trim;
    logic [21:0] ua3, ua2, mv;
    logic [2:0] m;
    int n_mismatch = 0;
    int checks = 0;
    lcsr_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    lcsr_regs DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ch3_current_code(code3), .ch2_current_code(code2), .ch3_switch(sw3),
        .ch2_switch(sw2), .ch1_switch(sw1), .direct_mode(dmode), .lockout_threshold_trim(trim),
        .ch3_current_ua(ua3), .ch2_current_ua(ua2), .lockout_threshold_mv(mv));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic compare(input logic [21:0] got, input logic [21:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rv);
        compare({14'h0000, rv}, {14'h0000, exp});
    endtask : rd_chk
    // Scaled targets land two edges after the write
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Watchdog against a hung bus
    initial
    begin
        #100000;
        n_mismatch++;
        final_report();
    end
    initial
    begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h07, 8'h00);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h09, 8'h00);
        host.write_reg(8'h07, 8'hFF);
        host.write_reg(8'h08, 8'hFF);
        host.write_reg(8'h05, 8'h03);
        host.write_reg(8'h06, 8'hFF);
        rd_chk(8'h07, 8'hFF);
        rd_chk(8'h08, 8'hFF);
        settle();
        compare({12'h000, code3}, 22'h0003FF);
        compare({12'h000, code2}, 22'h0003FF);
        compare(ua3, {10'h000, LCSR_STEP_UA} * 22'h0003FF);
        compare(ua2, {10'h000, LCSR_STEP_UA} * 22'h0003FF);
        // Undefined high bits must not leak into the code
        host.write_reg(8'h07, 8'hFC);
        settle();
        compare({12'h000, code3}, 22'h0000FF);
        host.write_reg(8'h09, 8'hE0);
        rd_chk(8'h09, 8'hE0);
        settle();
        compare({19'h00000, sw3, sw2, sw1}, 22'h000000);
        compare(mv, {10'h000, LCSR_UVLO_MIN_MV});
        host.write_reg(8'h11, 8'h01);
        for (int b = 0; b < 3; b++)
        begin
            m = 3'b001 << b;
            host.write_reg(8'h09, {m, 5'h1F});
            settle();
            compare({19'h00000, sw3, sw2, sw1}, {19'h00000, m});
            compare({21'h000000, dmode}, 22'h000001);
            compare({17'h00000, trim}, 22'h00001F);
            compare(mv, {10'h000, LCSR_UVLO_MIN_MV} + {10'h000, LCSR_UVLO_STEP_MV} * 22'h00001F);
        end
        host.write_reg(8'h0A, 8'h5A);
        rd_chk(8'h0A, 8'h00);
        // Mid-run reset, asserted and released on clock edges
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h08, 8'h00);
        settle();
        compare({19'h00000, sw3, sw2, sw1}, 22'h000000);
        compare(mv, {10'h000, LCSR_UVLO_MIN_MV});
        final_report();
    end
endmodule : led_current_switch_regs_bench
`default_nettype wire
